//--- hdl/tol_pkg.sv
// Constants, codes and field layouts shared by the settings block
package tol_pkg;
    // ==========================================================
    // Widths and memory depth
    localparam int ARG_W  = 26;
    localparam int MEAS_W = 20;
    localparam int TXT_W  = 152;
    localparam int MEM_D  = 1536;
    localparam int ADDR_W = 11;
    // ==========================================================
    // Command codes
    localparam logic [3:0] OP_CLOCK_SET  = 4'h1;
    localparam logic [3:0] OP_CLOCK_QRY  = 4'h2;
    localparam logic [3:0] OP_TRIG_SET   = 4'h3;
    localparam logic [3:0] OP_TRIG_QRY   = 4'h4;
    localparam logic [3:0] OP_DWELL_SET  = 4'h5;
    localparam logic [3:0] OP_DWELL_QRY  = 4'h6;
    localparam logic [3:0] OP_DEF_SET    = 4'h7;
    localparam logic [3:0] OP_DEF_QRY    = 4'h8;
    localparam logic [3:0] OP_BAND_SET   = 4'h9;
    localparam logic [3:0] OP_BAND_QRY   = 4'hA;
    localparam logic [3:0] OP_SIGMAP_SET = 4'hB;
    localparam logic [3:0] OP_SIGMAP_QRY = 4'hC;
    localparam logic [3:0] OP_STORE      = 4'hD;
    localparam logic [3:0] OP_RESET      = 4'hE;
    // ==========================================================
    // Trigger function codes
    localparam logic [3:0] FN_OFF = 4'h0;
    localparam logic [3:0] FN_OUT = 4'h1;
    localparam logic [3:0] FN_SQS = 4'h2;
    localparam logic [3:0] FN_SEQ = 4'h3;
    localparam logic [3:0] FN_LLO = 4'h4;
    localparam logic [3:0] FN_MIN = 4'h5;
    localparam logic [3:0] FN_AIX = 4'h6;
    localparam logic [3:0] FN_AIU = 4'h7;
    localparam logic [3:0] FN_AII = 4'h8;
    // Function output bit positions
    localparam int B_OUTPUT = 0;
    localparam int B_SEQ    = 1;
    localparam int B_LOCK   = 2;
    localparam int B_MINMAX = 3;
    localparam int B_UEXT   = 4;
    localparam int B_IEXT   = 5;
    localparam int B_SEQLED = 6;
    localparam int FN_W     = 7;
    // Signal output sources
    localparam logic [1:0] SIG_LOW  = 2'h0;
    localparam logic [1:0] SIG_VOLT = 2'h1;
    localparam logic [1:0] SIG_CURR = 2'h2;
    localparam logic [1:0] SIG_BOTH = 2'h3;
    // ==========================================================
    // Limits and values after reset, in mV, mA and ms; MEM_TOP in memory locations, CLOCK_RST as text
    localparam logic [ARG_W-1:0] UNOM_MV   = 26'h000EA60;
    localparam logic [ARG_W-1:0] INOM_MA   = 26'h0002710;
    localparam logic [ARG_W-1:0] DWELL_MAX = 26'h3E7FC18;
    localparam logic [ARG_W-1:0] DWELL_RST = 26'h0000000;
    localparam logic [ARG_W-1:0] DEF_RST   = 26'h0000001;
    localparam logic [ARG_W-1:0] MEM_TOP   = 26'h0000600;
    localparam logic [TXT_W-1:0] CLOCK_RST = "2000-01-01T00:00:00";
endpackage : tol_pkg

//--- hdl/band_if.sv
// Band references, measurements and comparison results between modules
`timescale 1ns/10ps
interface band_if;
    logic [1:0][tol_pkg::MEAS_W-1:0] meas;
    logic [1:0][tol_pkg::MEAS_W-1:0] lo;
    logic [1:0][tol_pkg::MEAS_W-1:0] hi;
    logic [1:0]                      in_band;
    modport ctrl (output meas, output lo, output hi, input in_band);
    modport cmp  (input meas, input lo, input hi, output in_band);
endinterface : band_if

//--- hdl/band_compare.sv
// Window comparator for voltage and current against the band references
`timescale 1ns/10ps
module band_compare (
    // Clock and reset, used by the checks only
    input  wire logic clk,
    input  wire logic reset,
    // Band signals
    band_if.cmp       bif
);
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            // Inclusive at both ends
            assign bif.in_band[g] = (bif.meas[g] >= bif.lo[g]) && (bif.meas[g] <= bif.hi[g]);

            edge_inside_a: assert property (@(posedge clk) disable iff (reset)
                ((bif.meas[g] == bif.lo[g]) || (bif.meas[g] == bif.hi[g])) |-> bif.in_band[g])
                else $error("Value on band edge not inside");
        end
    endgenerate
endmodule : band_compare

//--- hdl/tolerance_trigger_dwell_ctrl.sv
// Settings block: clock text, trigger functions, dwell times, tolerance band
`timescale 1ns/10ps
module tolerance_trigger_dwell_ctrl (
    // Clock and reset
    input  wire logic                                  clk,
    input  wire logic                                  reset,
    // Decoded host command
    input  wire logic                                  cmd_valid,
    input  wire logic [3:0]                            cmd_op,
    input  wire logic [3:0][tol_pkg::ARG_W-1:0]        cmd_args,
    input  wire logic [tol_pkg::TXT_W-1:0]             cmd_text,
    // Answer to queries
    output logic                                       resp_valid,
    output logic [3:0]                                 resp_op,
    output logic [3:0][tol_pkg::ARG_W-1:0]             resp_args,
    output logic [tol_pkg::TXT_W-1:0]                  resp_text,
    // Trigger inputs and what they drive
    input  wire logic [1:0]                            trig_in,
    output logic [1:0]                                 trigger_indicator,
    output logic [tol_pkg::FN_W-1:0]                   trig_fn,
    output logic                                       step_pulse,
    // Sequencer dwell lookup
    input  wire logic [tol_pkg::ADDR_W-1:0]            step_addr,
    output logic [tol_pkg::ARG_W-1:0]                  step_dwell_ms,
    // Measurements and status
    input  wire logic [tol_pkg::MEAS_W-1:0]            meas_volt,
    input  wire logic [tol_pkg::MEAS_W-1:0]            meas_curr,
    output logic [1:0]                                 condition_status_reg,
    output logic [1:0]                                 event_capture_reg,
    input  wire logic                                  event_clear,
    output logic                                       param_error,
    input  wire logic                                  error_clear,
    output logic [2:0]                                 signal_output_map
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [tol_pkg::TXT_W-1:0]            clock_text;
        logic [1:0][3:0]                      trig_mode;
        logic [1:0]                           trig_prev;
        logic [1:0]                           trig_ind;
        logic [tol_pkg::FN_W-1:0]             fn;
        logic                                 step;
        logic [tol_pkg::ARG_W-1:0]            dwell_cur;
        logic [tol_pkg::ARG_W-1:0]            dwell_def;
        logic [1:0][tol_pkg::MEAS_W-1:0]      band_lo;
        logic [1:0][tol_pkg::MEAS_W-1:0]      band_hi;
        logic [1:0]                           cond;
        logic [1:0]                           evt;
        logic                                 err;
        logic [2:0][1:0]                      sig_map;
        logic [2:0]                           sig;
        logic [tol_pkg::ARG_W-1:0]            step_dwell;
        logic                                 rvalid;
        logic [3:0]                           rop;
        logic [3:0][tol_pkg::ARG_W-1:0]       rargs;
        logic [tol_pkg::TXT_W-1:0]            rtext;
        logic [tol_pkg::MEM_D-1:0]            mem_valid;
    } state_t;

    state_t s_ff;
    state_t nxt_s;
    logic [tol_pkg::ARG_W-1:0] dwell_mem [tol_pkg::MEM_D];
    logic [tol_pkg::ARG_W-1:0] mem_rd;
    logic                      store_ok;
    logic [tol_pkg::ADDR_W-1:0] store_idx;

    band_if bif ();

    assign bif.meas[0] = meas_volt;
    assign bif.meas[1] = meas_curr;
    assign bif.lo      = s_ff.band_lo;
    assign bif.hi      = s_ff.band_hi;

    band_compare u_cmp (
        .clk   (clk),
        .reset (reset),
        .bif   (bif)
    );

    // ==========================================================
    // Clock text checks
    function automatic logic [7:0] ch(input logic [tol_pkg::TXT_W-1:0] t, input int i);
        ch = t[tol_pkg::TXT_W-1-8*i -: 8];
    endfunction : ch

    function automatic logic dig(input logic [7:0] c);
        dig = (c >= 8'h30) && (c <= 8'h39);
    endfunction : dig

    function automatic logic [6:0] num2(input logic [7:0] a, input logic [7:0] b);
        logic [6:0] hi;
        hi = 7'(a[3:0]) * 7'h0A;
        num2 = hi + 7'(b[3:0]);
    endfunction : num2

    function automatic logic clock_ok(input logic [tol_pkg::TXT_W-1:0] t);
        logic ok;
        logic [6:0] mo;
        logic [6:0] dy;
        ok = 1'b1;
        for (int i = 0; i < 19; i++) begin
            if (i == 4 || i == 7) begin
                ok = ok && (ch(t, i) == 8'h2D);
            end else if (i == 10) begin
                ok = ok && (ch(t, i) == 8'h54);
            end else if (i == 13 || i == 16) begin
                ok = ok && (ch(t, i) == 8'h3A);
            end else begin
                ok = ok && dig(ch(t, i));
            end
        end
        mo = num2(ch(t, 5), ch(t, 6));
        dy = num2(ch(t, 8), ch(t, 9));
        ok = ok && (ch(t, 0) >= 8'h32);
        ok = ok && (mo >= 7'h01) && (mo <= 7'h0C);
        ok = ok && (dy >= 7'h01) && (dy <= 7'h1F);
        ok = ok && (num2(ch(t, 11), ch(t, 12)) <= 7'h17);
        ok = ok && (num2(ch(t, 14), ch(t, 15)) <= 7'h3B);
        ok = ok && (num2(ch(t, 17), ch(t, 18)) <= 7'h3B);
        clock_ok = ok;
    endfunction : clock_ok

    // ==========================================================
    // Per-trigger decode
    logic [1:0][tol_pkg::FN_W-1:0] fn_of;
    logic [1:0]                    rise;
    logic [1:0]                    mode_ok;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_trig
            logic [3:0] m;
            assign m         = s_ff.trig_mode[g];
            assign rise[g]   = trig_in[g] && !s_ff.trig_prev[g] && (m == tol_pkg::FN_SQS);
            assign mode_ok[g] = (cmd_args[g] <= 26'(tol_pkg::FN_AII));
            always_comb begin
                fn_of[g] = '0;
                if (trig_in[g]) begin
                    case (m)
                        tol_pkg::FN_OUT: fn_of[g][tol_pkg::B_OUTPUT] = 1'b1;
                        tol_pkg::FN_SEQ: begin
                            fn_of[g][tol_pkg::B_SEQ]    = 1'b1;
                            fn_of[g][tol_pkg::B_SEQLED] = 1'b1;
                        end
                        tol_pkg::FN_SQS: fn_of[g][tol_pkg::B_SEQLED] = 1'b1;
                        tol_pkg::FN_LLO: fn_of[g][tol_pkg::B_LOCK]   = 1'b1;
                        tol_pkg::FN_MIN: fn_of[g][tol_pkg::B_MINMAX] = 1'b1;
                        tol_pkg::FN_AIX: begin
                            fn_of[g][tol_pkg::B_UEXT] = 1'b1;
                            fn_of[g][tol_pkg::B_IEXT] = 1'b1;
                        end
                        tol_pkg::FN_AIU: fn_of[g][tol_pkg::B_UEXT] = 1'b1;
                        tol_pkg::FN_AII: fn_of[g][tol_pkg::B_IEXT] = 1'b1;
                        default:         fn_of[g] = '0;
                    endcase
                end
            end
        end
    endgenerate

    localparam int ADDR_W = tol_pkg::ADDR_W;
    assign mem_rd    = dwell_mem[step_addr];
    assign store_idx = ADDR_W'(cmd_args[0] - 26'h0000001);
    assign store_ok  = cmd_valid && (cmd_op == tol_pkg::OP_STORE) && !reset
                       && (cmd_args[0] != '0) && (cmd_args[0] <= tol_pkg::MEM_TOP);

    // ==========================================================
    // Next state
    always_comb begin
        nxt_s           = s_ff;
        nxt_s.rvalid    = 1'b0;
        nxt_s.trig_prev = trig_in;
        nxt_s.step      = |rise;
        nxt_s.fn        = fn_of[0] | fn_of[1];
        for (int i = 0; i < 2; i++) begin
            nxt_s.trig_ind[i] = (s_ff.trig_mode[i] != tol_pkg::FN_OFF) && trig_in[i];
        end
        nxt_s.cond = bif.in_band;
        // A new result beats a clear in the same cycle
        nxt_s.evt  = (s_ff.evt & ~{2{event_clear}}) | bif.in_band;
        nxt_s.err  = s_ff.err && !error_clear;
        for (int i = 0; i < 3; i++) begin
            case (s_ff.sig_map[i])
                tol_pkg::SIG_VOLT: nxt_s.sig[i] = bif.in_band[0];
                tol_pkg::SIG_CURR: nxt_s.sig[i] = bif.in_band[1];
                tol_pkg::SIG_BOTH: nxt_s.sig[i] = &bif.in_band;
                default:           nxt_s.sig[i] = 1'b0;
            endcase
        end
        // Out-of-range address or never-stored location falls back too
        if ((step_addr < tol_pkg::MEM_D[ADDR_W-1:0]) && s_ff.mem_valid[step_addr]
            && (mem_rd != '0)) begin
            nxt_s.step_dwell = mem_rd;
        end else begin
            nxt_s.step_dwell = s_ff.dwell_def;
        end
        if (cmd_valid) begin
            nxt_s.rop   = cmd_op;
            nxt_s.rargs = '0;
            case (cmd_op)
                tol_pkg::OP_CLOCK_SET: begin
                    if (clock_ok(cmd_text)) nxt_s.clock_text = cmd_text;
                    else nxt_s.err = 1'b1;
                end
                tol_pkg::OP_CLOCK_QRY: begin
                    nxt_s.rvalid = 1'b1;
                    nxt_s.rtext  = s_ff.clock_text;
                end
                tol_pkg::OP_TRIG_SET: begin
                    if (&mode_ok) begin
                        nxt_s.trig_mode[0] = cmd_args[0][3:0];
                        nxt_s.trig_mode[1] = cmd_args[1][3:0];
                    end else nxt_s.err = 1'b1;
                end
                tol_pkg::OP_TRIG_QRY: begin
                    nxt_s.rvalid   = 1'b1;
                    nxt_s.rargs[0] = 26'(s_ff.trig_mode[0]);
                    nxt_s.rargs[1] = 26'(s_ff.trig_mode[1]);
                end
                tol_pkg::OP_DWELL_SET: begin
                    if (cmd_args[0] <= tol_pkg::DWELL_MAX) nxt_s.dwell_cur = cmd_args[0];
                    else nxt_s.err = 1'b1;
                end
                tol_pkg::OP_DWELL_QRY: begin
                    nxt_s.rvalid   = 1'b1;
                    nxt_s.rargs[0] = s_ff.dwell_cur;
                end
                tol_pkg::OP_DEF_SET: begin
                    if ((cmd_args[0] != '0) && (cmd_args[0] <= tol_pkg::DWELL_MAX)) begin
                        nxt_s.dwell_def = cmd_args[0];
                    end else nxt_s.err = 1'b1;
                end
                tol_pkg::OP_DEF_QRY: begin
                    nxt_s.rvalid   = 1'b1;
                    nxt_s.rargs[0] = s_ff.dwell_def;
                end
                tol_pkg::OP_BAND_SET: begin
                    if ((cmd_args[0] < cmd_args[1]) && (cmd_args[1] <= tol_pkg::UNOM_MV)
                        && (cmd_args[2] < cmd_args[3]) && (cmd_args[3] <= tol_pkg::INOM_MA)) begin
                        nxt_s.band_lo[0] = cmd_args[0][tol_pkg::MEAS_W-1:0];
                        nxt_s.band_hi[0] = cmd_args[1][tol_pkg::MEAS_W-1:0];
                        nxt_s.band_lo[1] = cmd_args[2][tol_pkg::MEAS_W-1:0];
                        nxt_s.band_hi[1] = cmd_args[3][tol_pkg::MEAS_W-1:0];
                    end else nxt_s.err = 1'b1;
                end
                tol_pkg::OP_BAND_QRY: begin
                    nxt_s.rvalid   = 1'b1;
                    nxt_s.rargs[0] = 26'(s_ff.band_lo[0]);
                    nxt_s.rargs[1] = 26'(s_ff.band_hi[0]);
                    nxt_s.rargs[2] = 26'(s_ff.band_lo[1]);
                    nxt_s.rargs[3] = 26'(s_ff.band_hi[1]);
                end
                tol_pkg::OP_SIGMAP_SET: begin
                    if ((cmd_args[0] <= 26'h3) && (cmd_args[1] <= 26'h3) && (cmd_args[2] <= 26'h3)) begin
                        for (int i = 0; i < 3; i++) nxt_s.sig_map[i] = cmd_args[i][1:0];
                    end else nxt_s.err = 1'b1;
                end
                tol_pkg::OP_SIGMAP_QRY: begin
                    nxt_s.rvalid = 1'b1;
                    for (int i = 0; i < 3; i++) nxt_s.rargs[i] = 26'(s_ff.sig_map[i]);
                end
                tol_pkg::OP_STORE: begin
                    if (store_ok) nxt_s.mem_valid[store_idx] = 1'b1;
                    else nxt_s.err = 1'b1;
                end
                tol_pkg::OP_RESET: begin
                    // Clock text survives a reset command
                    nxt_s.trig_mode = '0;
                    nxt_s.dwell_cur = tol_pkg::DWELL_RST;
                    nxt_s.dwell_def = tol_pkg::DEF_RST;
                    nxt_s.band_lo   = '0;
                    nxt_s.band_hi[0] = tol_pkg::UNOM_MV[tol_pkg::MEAS_W-1:0];
                    nxt_s.band_hi[1] = tol_pkg::INOM_MA[tol_pkg::MEAS_W-1:0];
                end
                default: nxt_s.err = 1'b1;
            endcase
        end
        if (reset) begin
            nxt_s            = '0;
            nxt_s.clock_text = tol_pkg::CLOCK_RST;
            nxt_s.dwell_def  = tol_pkg::DEF_RST;
            nxt_s.step_dwell = tol_pkg::DEF_RST;
            nxt_s.band_hi[0] = tol_pkg::UNOM_MV[tol_pkg::MEAS_W-1:0];
            nxt_s.band_hi[1] = tol_pkg::INOM_MA[tol_pkg::MEAS_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        s_ff <= nxt_s;
    end

    // Memory has no reset; validity bits stand in for it
    always_ff @(posedge clk) begin
        if (store_ok) begin
            dwell_mem[store_idx] <= s_ff.dwell_cur;
        end
    end

    assign resp_valid           = s_ff.rvalid;
    assign resp_op              = s_ff.rop;
    assign resp_args            = s_ff.rargs;
    assign resp_text            = s_ff.rtext;
    assign trigger_indicator    = s_ff.trig_ind;
    assign trig_fn              = s_ff.fn;
    assign step_pulse           = s_ff.step;
    assign step_dwell_ms        = s_ff.step_dwell;
    assign condition_status_reg = s_ff.cond;
    assign event_capture_reg    = s_ff.evt;
    assign param_error          = s_ff.err;
    assign signal_output_map    = s_ff.sig;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence sqs_rise_s(int k);
        (s_ff.trig_mode[k] == tol_pkg::FN_SQS) && !trig_in[k]
        ##1 trig_in[k] && (s_ff.trig_mode[k] == tol_pkg::FN_SQS);
    endsequence

    step_on_edge_a: assert property (sqs_rise_s(0) |=> step_pulse)
        else $error("Single-step edge gave no pulse");
    second_step_edge_a: assert property (sqs_rise_s(1) |=> step_pulse)
        else $error("Single-step edge on input 1 gave no pulse");
    step_single_a: assert property (step_pulse |->
        ($past(trig_in[0]) && !$past(trig_in[0], 2)
         && $past(s_ff.trig_mode[0]) == tol_pkg::FN_SQS)
        || ($past(trig_in[1]) && !$past(trig_in[1], 2)
         && $past(s_ff.trig_mode[1]) == tol_pkg::FN_SQS))
        else $error("Step pulse without edge");
    trig_off_a: assert property (cmd_valid && cmd_op == tol_pkg::OP_RESET |=>
        s_ff.trig_mode == '0 ##1 trigger_indicator == 2'h0)
        else $error("Triggers not off after reset command");
    ind_gate_a: assert property (trigger_indicator[0] |->
        $past(trig_in[0]) && $past(s_ff.trig_mode[0]) != tol_pkg::FN_OFF)
        else $error("Indicator lit without active function");
    clock_query_a: assert property (cmd_valid && cmd_op == tol_pkg::OP_CLOCK_QRY |=>
        resp_valid && resp_text == $past(s_ff.clock_text))
        else $error("Clock answer wrong");
    clock_reject_a: assert property (cmd_valid && cmd_op == tol_pkg::OP_CLOCK_SET
        && !clock_ok(cmd_text) |=> param_error && $stable(s_ff.clock_text))
        else $error("Bad clock text accepted");
    band_order_a: assert property (s_ff.band_lo[0] < s_ff.band_hi[0]
        && s_ff.band_lo[1] < s_ff.band_hi[1])
        else $error("Band lower not below upper");
    // Skip the edge after reset: result was live while the flops were held
    cond_follow_a: assert property (!$past(reset) |->
        condition_status_reg == $past(bif.in_band)
        && (($past(bif.in_band) & ~event_capture_reg) == 2'h0))
        else $error("Condition or event bits lag result");
    dwell_default_a: assert property (step_dwell_ms != '0
        && step_dwell_ms <= tol_pkg::DWELL_MAX)
        else $error("Effective dwell zero or too long");
    def_range_a: assert property (s_ff.dwell_def != '0)
        else $error("Default dwell zero");
endmodule : tolerance_trigger_dwell_ctrl

//--- sim/host_model.sv
// Host side model: issues decoded commands one strobe at a time
`timescale 1ns/10ps
module host_model (
    // Clock
    input  wire logic                      clk,
    // Command out
    output logic                           cmd_valid,
    output logic [3:0]                     cmd_op,
    output logic [3:0][tol_pkg::ARG_W-1:0] cmd_args,
    output logic [tol_pkg::TXT_W-1:0]      cmd_text
);
    initial begin
        cmd_valid = 1'b0;
        cmd_op = 4'h0;
        cmd_args = '0;
        cmd_text = '0;
    end
    // Lower before upper in each band pair is up to the caller
    task automatic send(input logic [3:0] op, input logic [3:0][tol_pkg::ARG_W-1:0] a,
                        input logic [tol_pkg::TXT_W-1:0] t);
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_args = a;
        cmd_text = t;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        // Released fields show no stale value
        cmd_op = ~op;
        cmd_args = ~a;
        cmd_text = ~t;
    endtask : send
endmodule : host_model

//--- sim/tb.sv
// Testbench for the settings block
`timescale 1ns/10ps
module tb;
    logic clk = 1'b0, reset = 1'b1, event_clear = 1'b0, error_clear = 1'b0;
    logic [1:0] trig_in = 2'h0;
    logic [10:0] step_addr = 11'h000;
    logic [19:0] meas_volt = 20'h00000, meas_curr = 20'h00000;
    logic cmd_valid, resp_valid, step_pulse, param_error;
    logic [3:0] cmd_op, resp_op;
    logic [3:0][25:0] cmd_args, resp_args;
    logic [151:0] cmd_text, resp_text;
    logic [1:0] trigger_indicator, condition_status_reg, event_capture_reg;
    logic [6:0] trig_fn;
    logic [25:0] step_dwell_ms;
    logic [2:0] signal_output_map;
    int n_tests = 0, fail_count = 0, n;
    always #5 clk = ~clk;
    host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_args(cmd_args), .cmd_text(cmd_text));
    tolerance_trigger_dwell_ctrl dut (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_args(cmd_args), .cmd_text(cmd_text), .resp_valid(resp_valid),
        .resp_op(resp_op), .resp_args(resp_args), .resp_text(resp_text), .trig_in(trig_in),
        .trigger_indicator(trigger_indicator), .trig_fn(trig_fn), .step_pulse(step_pulse),
        .step_addr(step_addr), .step_dwell_ms(step_dwell_ms), .meas_volt(meas_volt),
        .meas_curr(meas_curr), .condition_status_reg(condition_status_reg),
        .event_capture_reg(event_capture_reg), .event_clear(event_clear),
        .param_error(param_error), .error_clear(error_clear),
        .signal_output_map(signal_output_map));
    function automatic logic [3:0][25:0] a(input logic [25:0] w, x = 0, y = 0, z = 0);
        return {z, y, x, w};
    endfunction : a
    task automatic chk(input logic [151:0] s, input logic [151:0] e);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, s, e);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks=%0d failures=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    task automatic q(input logic [3:0] op);
        host.send(op, '0, '0);
        chk(resp_valid, 1'b1);
        chk(resp_op, op);
    endtask : q
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    initial begin
        #100000;
        fail_count++;
        stop_test();
    end
    initial begin
        tick(3);
        reset = 1'b0;
        q(tol_pkg::OP_BAND_QRY);
        chk(resp_args, a(0, tol_pkg::UNOM_MV, 0, tol_pkg::INOM_MA));
        q(tol_pkg::OP_DEF_QRY);
        chk(resp_args[0], 26'h0000001);
        q(tol_pkg::OP_DWELL_QRY);
        chk(resp_args[0], 26'h0000000);
        host.send(tol_pkg::OP_CLOCK_SET, '0, "2024-12-31T23:59:59");
        q(tol_pkg::OP_CLOCK_QRY);
        chk(resp_text, "2024-12-31T23:59:59");
        host.send(tol_pkg::OP_CLOCK_SET, '0, "1999-13-01T00:00:00");
        chk(param_error, 1'b1);
        host.send(tol_pkg::OP_CLOCK_SET, '0, "2024/12-31T23:59:59");
        q(tol_pkg::OP_CLOCK_QRY);
        chk(resp_text, "2024-12-31T23:59:59");
        error_clear = 1'b1;
        tick(1);
        error_clear = 1'b0;
        tick(1);
        chk(param_error, 1'b0);
        host.send(tol_pkg::OP_BAND_SET, a(1000, 2000, 100, 200), '0);
        host.send(tol_pkg::OP_SIGMAP_SET, a(tol_pkg::SIG_VOLT, tol_pkg::SIG_CURR), '0);
        meas_volt = 20'h003E8;
        meas_curr = 20'h000C8;
        tick(3);
        chk(condition_status_reg, 2'h3);
        meas_volt = 20'h003E7;
        tick(3);
        chk(condition_status_reg, 2'h2);
        chk(event_capture_reg, 2'h3);
        chk(signal_output_map, 3'h2);
        event_clear = 1'b1;
        tick(1);
        event_clear = 1'b0;
        tick(1);
        chk(event_capture_reg, 2'h2);
        host.send(tol_pkg::OP_BAND_SET, a(2000, 2000, 100, 200), '0);
        chk(param_error, 1'b1);
        q(tol_pkg::OP_BAND_QRY);
        chk(resp_args, a(1000, 2000, 100, 200));
        host.send(tol_pkg::OP_TRIG_SET, a(tol_pkg::FN_OUT, tol_pkg::FN_SQS), '0);
        tick(1);
        trig_in = 2'h3;
        n = 0;
        repeat (6) begin
            tick(1);
            if (step_pulse === 1'b1) n++;
        end
        chk(n, 1);
        chk(trigger_indicator, 2'h3);
        chk(trig_fn[tol_pkg::B_OUTPUT], 1'b1);
        host.send(tol_pkg::OP_TRIG_SET, a(tol_pkg::FN_SEQ, tol_pkg::FN_AIU), '0);
        tick(2);
        chk(trig_fn, 7'h52);
        host.send(tol_pkg::OP_TRIG_SET, a(tol_pkg::FN_LLO, tol_pkg::FN_AII), '0);
        tick(2);
        chk(trig_fn, 7'h24);
        host.send(tol_pkg::OP_TRIG_SET, a(tol_pkg::FN_MIN, tol_pkg::FN_AIX), '0);
        tick(2);
        chk(trig_fn, 7'h38);
        chk(trigger_indicator, 2'h3);
        host.send(tol_pkg::OP_TRIG_SET, a(26'h0000009, tol_pkg::FN_OUT), '0);
        q(tol_pkg::OP_TRIG_QRY);
        chk(resp_args[0], 26'h0000005);
        chk(resp_args[1], 26'h0000006);
        host.send(tol_pkg::OP_RESET, '0, '0);
        q(tol_pkg::OP_TRIG_QRY);
        chk(resp_args[1:0], 52'h0);
        tick(2);
        chk(trigger_indicator, 2'h0);
        chk(step_dwell_ms, 26'h0000001);
        host.send(tol_pkg::OP_DWELL_SET, a(5), '0);
        host.send(tol_pkg::OP_STORE, a(1), '0);
        tick(2);
        chk(step_dwell_ms, 26'h0000005);
        host.send(tol_pkg::OP_DEF_SET, a(7), '0);
        step_addr = 11'h001;
        tick(2);
        chk(step_dwell_ms, 26'h0000007);
        stop_test();
    end
endmodule : tb
